// [rtl/bwd_window_decoder.sv]
// Behaviour
// - Channel count limit register reads fixed 04h, read-only.
// - Modules per channel limit register reads fixed 04h, read-only.
// - Module limit covers only slot select codes 0h through 7h.
// - Window decodes in 2 KB ranges, one buffer per range.
// - Window hits become channel commands, gated by presence.
// - In-range offset is function (upper 3 bits) and register offset (lower 8).
// - Window 0h-7FFFh is channel 0, sixteen 2 KB slots.
// - Window 8000h-FFFFh is channel 1, sixteen 2 KB slots.
// - Window 10000h-17FFFh is channel 2, sixteen 2 KB slots.
// - Window 18000h-1FFFFh is channel 3, sixteen 2 KB slots.
// - Writable window base holds bits 39:17, resets to 0xFE00_0000.
// - Slot with presence bit clear never gets a configuration command.
`timescale 1ns/10ps
module bwd_window_decoder (
  input  wire logic                              i_clk,
  input  wire logic                              i_reset,
  input  wire logic                              i_host_req,
  input  wire logic                              i_host_write,
  input  wire logic [bwd_pkg::HOST_ADDR_W-1:0]   i_host_addr,
  input  wire logic [31:0]                       i_host_wdata,
  input  wire logic                              i_cfg_rd,
  input  wire logic                              i_cfg_wr,
  input  wire logic [7:0]                        i_cfg_addr,
  input  wire logic [3:0]                        i_cfg_be,
  input  wire logic [31:0]                       i_cfg_wdata,
  output logic                                   o_host_claim,
  output logic                                   o_host_abort,
  output logic                                   o_cmd_valid,
  output logic                                   o_cmd_write,
  output logic [bwd_pkg::CH_W-1:0]               o_cmd_channel,
  output logic [bwd_pkg::SLOT_W-1:0]             o_cmd_slot,
  output logic [bwd_pkg::FUNC_W-1:0]             o_cmd_function,
  output logic [bwd_pkg::OFS_W-1:0]              o_cmd_offset,
  output logic [31:0]                            o_cmd_wdata,
  output logic                                   o_cmd_module_slot,
  output logic [31:0]                            o_cfg_rdata,
  output logic                                   o_cfg_rvalid
);

  logic [bwd_pkg::BASE_W-1:0]   base_ff;
  logic [bwd_pkg::PRES_W-1:0]   presence_ff;
  logic                         claim_ff;
  logic                         abort_ff;
  logic                         cmd_valid_ff;
  logic                         cmd_write_ff;
  logic [bwd_pkg::CH_W-1:0]     cmd_channel_ff;
  logic [bwd_pkg::SLOT_W-1:0]   cmd_slot_ff;
  logic [bwd_pkg::FUNC_W-1:0]   cmd_function_ff;
  logic [bwd_pkg::OFS_W-1:0]    cmd_offset_ff;
  logic [31:0]                  cmd_wdata_ff;
  logic                         cmd_module_slot_ff;
  logic [31:0]                  cfg_rdata_ff;
  logic                         cfg_rvalid_ff;
  logic [31:0]                  nxt_cfg_rdata;
  logic                         slot_present;
  logic                         take_hit;
  logic [5:0]                   cfg_dword;

  bwd_split_if sp ();

  assign sp.addr = i_host_addr;
  assign sp.base = base_ff;

  bwd_addr_split u_split (
    .sp (sp)
  );

  assign cfg_dword    = bwd_pkg::dword_of(i_cfg_addr);
  assign slot_present = presence_ff[bwd_pkg::presence_index(sp.channel, sp.slot)];
  assign take_hit     = i_host_req & sp.hit;

  // Window base register; a relocation takes effect on the next request
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      base_ff <= bwd_pkg::BASE_RESET;
    end else if (i_cfg_wr) begin
      if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_WINDOW_BASE_LO)) begin
        if (i_cfg_be[2]) begin
          base_ff[6:0] <= i_cfg_wdata[23:17];
        end
        if (i_cfg_be[3]) begin
          base_ff[14:7] <= i_cfg_wdata[31:24];
        end
      end else if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_WINDOW_BASE_HI)) begin
        if (i_cfg_be[0]) begin
          base_ff[22:15] <= i_cfg_wdata[7:0];
        end
      end
    end
  end

  // Presence mask, bit {channel, slot}; cleared at reset so nothing is sent unprogrammed
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      presence_ff <= bwd_pkg::PRES_RESET;
    end else if (i_cfg_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (i_cfg_be[b] && cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_PRESENCE_LO)) begin
          presence_ff[8*b +: 8] <= i_cfg_wdata[8*b +: 8];
        end
        if (i_cfg_be[b] && cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_PRESENCE_HI)) begin
          presence_ff[32 + 8*b +: 8] <= i_cfg_wdata[8*b +: 8];
        end
      end
    end
  end

  // Host side: claim any window hit, issue only to present slots
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      claim_ff     <= 1'b0;
      abort_ff     <= 1'b0;
      cmd_valid_ff <= 1'b0;
    end else begin
      claim_ff     <= take_hit;
      cmd_valid_ff <= take_hit & slot_present;
      abort_ff     <= take_hit & ~slot_present;
    end
  end

  // Command fields hold between hits so the channel side sees stable values
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_write_ff       <= 1'b0;
      cmd_channel_ff     <= '0;
      cmd_slot_ff        <= '0;
      cmd_function_ff    <= '0;
      cmd_offset_ff      <= '0;
      cmd_wdata_ff       <= '0;
      cmd_module_slot_ff <= 1'b0;
    end else if (take_hit) begin
      cmd_write_ff       <= i_host_write;
      cmd_channel_ff     <= sp.channel;
      cmd_slot_ff        <= sp.slot;
      cmd_function_ff    <= sp.func;
      cmd_offset_ff      <= sp.offset;
      cmd_wdata_ff       <= i_host_wdata;
      cmd_module_slot_ff <= (sp.slot <= bwd_pkg::MODULE_SLOT_MAX);
    end
  end

  // Read mux; unmapped dwords read as zero, writes to read-only fields are dropped
  always_comb begin
    nxt_cfg_rdata = 32'h0;
    if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_WINDOW_BASE_LO)) begin
      nxt_cfg_rdata = {base_ff[14:0], 17'h0};
    end else if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_WINDOW_BASE_HI)) begin
      nxt_cfg_rdata = {24'h0, base_ff[22:15]};
    end else if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_CHANNEL_COUNT_LIMIT)) begin
      nxt_cfg_rdata[bwd_pkg::CH_COUNT_POS +: 8]  = bwd_pkg::CHANNEL_COUNT_VALUE;
      nxt_cfg_rdata[bwd_pkg::MOD_LIMIT_POS +: 8] = bwd_pkg::MODULES_PER_CH_VALUE;
    end else if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_PRESENCE_LO)) begin
      nxt_cfg_rdata = presence_ff[31:0];
    end else if (cfg_dword == bwd_pkg::dword_of(bwd_pkg::OFS_PRESENCE_HI)) begin
      nxt_cfg_rdata = presence_ff[63:32];
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_rdata_ff  <= 32'h0;
      cfg_rvalid_ff <= 1'b0;
    end else begin
      cfg_rvalid_ff <= i_cfg_rd;
      if (i_cfg_rd) begin
        cfg_rdata_ff <= nxt_cfg_rdata;
      end
    end
  end

  assign o_host_claim      = claim_ff;
  assign o_host_abort      = abort_ff;
  assign o_cmd_valid       = cmd_valid_ff;
  assign o_cmd_write       = cmd_write_ff;
  assign o_cmd_channel     = cmd_channel_ff;
  assign o_cmd_slot        = cmd_slot_ff;
  assign o_cmd_function    = cmd_function_ff;
  assign o_cmd_offset      = cmd_offset_ff;
  assign o_cmd_wdata       = cmd_wdata_ff;
  assign o_cmd_module_slot = cmd_module_slot_ff;
  assign o_cfg_rdata       = cfg_rdata_ff;
  assign o_cfg_rvalid      = cfg_rvalid_ff;

  AST_CH_COUNT_READ: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cfg_rd && i_cfg_addr[7:2] == 6'h15 |=> o_cfg_rvalid && o_cfg_rdata[23:16] == 8'h04)
    else $error("channel count limit did not read 04h");

  AST_MOD_LIMIT_READ: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cfg_wr && i_cfg_addr[7:2] == 6'h15 ##2 i_cfg_rd && i_cfg_addr[7:2] == 6'h15
    |=> o_cfg_rdata[31:24] == 8'h04)
    else $error("modules per channel limit changed or misread");

  AST_MODULE_SLOT: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff
    |=> o_cmd_module_slot == ($past(i_host_addr[14]) == 1'b0))
    else $error("module slot flag wrong for slot code");

  AST_CMD_NEEDS_PRESENT: assert property (@(posedge i_clk) disable iff (i_reset)
    o_cmd_valid |-> o_host_claim && !o_host_abort && $past(slot_present))
    else $error("command issued without a present slot");

  AST_FUNC_OFFSET: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff
    |=> {o_cmd_function, o_cmd_offset} == $past(i_host_addr[10:0]))
    else $error("function and offset not taken from low 11 bits");

  AST_CHANNEL0: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff && i_host_addr[16:0] <= 17'h07fff
    |=> o_host_claim && o_cmd_channel == 2'd0 && o_cmd_slot == $past(i_host_addr[14:11]))
    else $error("channel 0 window range misdecoded");

  AST_CHANNEL1: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff && i_host_addr[16:0] >= 17'h08000
    && i_host_addr[16:0] <= 17'h0ffff
    |=> o_host_claim && o_cmd_channel == 2'd1 && o_cmd_slot == $past(i_host_addr[14:11]))
    else $error("channel 1 window range misdecoded");

  AST_CHANNEL2: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff && i_host_addr[16:0] >= 17'h10000
    && i_host_addr[16:0] <= 17'h17fff
    |=> o_cmd_channel == 2'd2 && o_cmd_slot == $past(i_host_addr[14:11]))
    else $error("channel 2 window range misdecoded");

  AST_CHANNEL3: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff && i_host_addr[16:0] >= 17'h18000
    |=> o_cmd_channel == 2'd3 && o_cmd_slot == $past(i_host_addr[14:11]))
    else $error("channel 3 window range misdecoded");

  AST_BASE_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cfg_wr && i_cfg_addr[7:2] == 6'h12 && i_cfg_be == 4'hf
    |=> base_ff[14:0] == $past(i_cfg_wdata[31:17]))
    else $error("window base low bits not written");

  AST_ABSENT_NO_CMD: assert property (@(posedge i_clk) disable iff (i_reset)
    i_host_req && i_host_addr[39:17] == base_ff && !slot_present
    |=> !o_cmd_valid && o_host_abort ##1 !o_cmd_valid || $past(i_host_req))
    else $error("command sent to slot with presence clear");

  AST_NO_CLAIM_OUTSIDE: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_host_req && i_host_addr[39:17] == base_ff) |=> !o_host_claim && !o_cmd_valid)
    else $error("access outside window was claimed");

endmodule // bwd_window_decoder

// [rtl/bwd_pkg.sv]
package bwd_pkg;

  // Host address and window geometry
  localparam int unsigned HOST_ADDR_W = 40;
  localparam int unsigned BASE_LSB    = 17;
  localparam int unsigned BASE_W      = 23;
  localparam int unsigned CH_LSB      = 15;
  localparam int unsigned CH_W        = 2;
  localparam int unsigned SLOT_LSB    = 11;
  localparam int unsigned SLOT_W      = 4;
  localparam int unsigned FUNC_LSB    = 8;
  localparam int unsigned FUNC_W      = 3;
  localparam int unsigned OFS_W       = 8;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned NUM_SLOT    = 16;
  localparam int unsigned PRES_W      = NUM_CH * NUM_SLOT;

  // Window base reset: 0xFE00_0000 >> 17
  localparam logic [BASE_W-1:0] BASE_RESET = 23'h007f00;
  localparam logic [PRES_W-1:0] PRES_RESET = 64'h0;

  // Codes 0..7 are modules in the channel
  localparam logic [SLOT_W-1:0] MODULE_SLOT_MAX = 4'h7;

  // Fixed capability values
  localparam logic [7:0] CHANNEL_COUNT_VALUE  = 8'h04;
  localparam logic [7:0] MODULES_PER_CH_VALUE = 8'h04;

  // Configuration register byte offsets
  localparam logic [7:0] OFS_WINDOW_BASE_LO      = 8'h48;
  localparam logic [7:0] OFS_WINDOW_BASE_HI      = 8'h4c;
  localparam logic [7:0] OFS_CHANNEL_COUNT_LIMIT = 8'h56;
  localparam logic [7:0] OFS_MODULES_PER_CH_LIM  = 8'h57;
  localparam logic [7:0] OFS_PRESENCE_LO         = 8'h64;
  localparam logic [7:0] OFS_PRESENCE_HI         = 8'h68;

  // Field positions inside the dwords
  localparam int unsigned BASE_HI_W = 8;
  localparam int unsigned CH_COUNT_POS   = 8 * int'(OFS_CHANNEL_COUNT_LIMIT[1:0]);
  localparam int unsigned MOD_LIMIT_POS  = 8 * int'(OFS_MODULES_PER_CH_LIM[1:0]);

  function automatic logic [5:0] presence_index(input logic [CH_W-1:0]   ch,
                                                input logic [SLOT_W-1:0] slot);
    return {ch, slot};
  endfunction

  function automatic logic [5:0] dword_of(input logic [7:0] byte_addr);
    return byte_addr[7:2];
  endfunction

endpackage

// [rtl/bwd_split_if.sv]
`timescale 1ns/10ps
interface bwd_split_if;
  logic [bwd_pkg::HOST_ADDR_W-1:0] addr;
  logic [bwd_pkg::BASE_W-1:0]      base;
  logic                            hit;
  logic [bwd_pkg::CH_W-1:0]        channel;
  logic [bwd_pkg::SLOT_W-1:0]      slot;
  logic [bwd_pkg::FUNC_W-1:0]      func;
  logic [bwd_pkg::OFS_W-1:0]       offset;

  modport decoder (input addr, base, output hit, channel, slot, func, offset);
  modport user    (output addr, base, input hit, channel, slot, func, offset);
endinterface

// [rtl/bwd_addr_split.sv]
`timescale 1ns/10ps
module bwd_addr_split (
  bwd_split_if.decoder sp
);
  // Window claims only its own 128 KB; base compare is on bits 39:17
  assign sp.hit     = (sp.addr[bwd_pkg::HOST_ADDR_W-1:bwd_pkg::BASE_LSB] == sp.base);
  // Four 32 KB channel quarters, sixteen 2 KB slots in each
  assign sp.channel = sp.addr[bwd_pkg::CH_LSB +: bwd_pkg::CH_W];
  assign sp.slot    = sp.addr[bwd_pkg::SLOT_LSB +: bwd_pkg::SLOT_W];
  assign sp.func    = sp.addr[bwd_pkg::FUNC_LSB +: bwd_pkg::FUNC_W];
  assign sp.offset  = sp.addr[bwd_pkg::OFS_W-1:0];
endmodule // bwd_addr_split

// [verif/bwd_buffer_model.sv]
`timescale 1ns/10ps
module bwd_buffer_model (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_clear,
  input  wire logic                       i_cmd_valid,
  input  wire logic [bwd_pkg::CH_W-1:0]   i_cmd_channel,
  input  wire logic [bwd_pkg::SLOT_W-1:0] i_cmd_slot,
  output logic      [bwd_pkg::PRES_W-1:0] o_seen,
  output logic      [15:0]                o_count
);
  logic [bwd_pkg::PRES_W-1:0] seen_ff;
  logic [15:0]                count_ff;

  // Marks every buffer that took a command, so a stray one to an absent slot shows up
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seen_ff  <= '0;
      count_ff <= 16'h0000;
    end else if (i_clear) begin
      seen_ff  <= '0;
      count_ff <= 16'h0000;
    end else if (i_cmd_valid) begin
      seen_ff[{i_cmd_channel, i_cmd_slot}] <= 1'b1;
      count_ff                             <= count_ff + 16'h0001;
    end
  end

  assign o_seen  = seen_ff;
  assign o_count = count_ff;
endmodule // bwd_buffer_model

// [verif/tb_bwd_window_decoder.sv]
`timescale 1ns/10ps
module tb_bwd_window_decoder;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        req = 1'b0, wr = 1'b0, crd = 1'b0, cwr = 1'b0, clr = 1'b0;
  logic [39:0] haddr = 40'h0;
  logic [31:0] hdata = 32'h0, cdata = 32'h0;
  logic [7:0]  caddr = 8'h0;
  logic [3:0]  cbe = 4'h0;
  logic        claim, abort, cvalid, cwrite, cmod, rvalid;
  logic [1:0]  cch;
  logic [3:0]  cslot;
  logic [2:0]  cfn;
  logic [7:0]  cofs;
  logic [31:0] cwdata, rdata;
  logic [63:0] seen;
  logic [15:0] count;
  int          fails = 0, n_checks = 0, cycles = 0;
  logic [39:0] base = 40'h00_fe00_0000;

  bwd_window_decoder dut (.i_clk(i_clk), .i_reset(i_reset), .i_host_req(req),
    .i_host_write(wr), .i_host_addr(haddr), .i_host_wdata(hdata), .i_cfg_rd(crd),
    .i_cfg_wr(cwr), .i_cfg_addr(caddr), .i_cfg_be(cbe), .i_cfg_wdata(cdata),
    .o_host_claim(claim), .o_host_abort(abort), .o_cmd_valid(cvalid), .o_cmd_write(cwrite),
    .o_cmd_channel(cch), .o_cmd_slot(cslot), .o_cmd_function(cfn), .o_cmd_offset(cofs),
    .o_cmd_wdata(cwdata), .o_cmd_module_slot(cmod), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid));

  bwd_buffer_model model (.i_clk(i_clk), .i_reset(i_reset), .i_clear(clr),
    .i_cmd_valid(cvalid), .i_cmd_channel(cch), .i_cmd_slot(cslot), .o_seen(seen),
    .o_count(count));

  always #5 i_clk = ~i_clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    {cwr, caddr, cbe, cdata} = {1'b1, a, 4'hf, d};
    @(negedge i_clk);
    cwr = 1'b0;
  endtask

  // Answer is registered: it stands in the cycle after the taking edge
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge i_clk);
    {crd, caddr} = {1'b1, a};
    @(negedge i_clk);
    crd = 1'b0;
    check({rvalid, rdata}, {1'b1, exp});
  endtask

  task automatic host(input logic [39:0] a, input logic w, input logic [31:0] d,
                      input logic [2:0] exp);
    @(negedge i_clk);
    {req, wr, haddr, hdata} = {1'b1, w, a, d};
    @(negedge i_clk);
    req = 1'b0;
    check({claim, cvalid, abort}, exp);
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    logic [39:0] a;
    logic [10:0] off;
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    cfg_read(8'h54, 32'h0404_0000);
    cfg_read(8'h48, 32'hfe00_0000);
    cfg_read(8'h4c, 32'h0);
    cfg_write(8'h54, 32'hffff_ffff);
    cfg_read(8'h54, 32'h0404_0000);
    $display("test registers done");
    host(base | 40'h0a123, 1'b0, 32'h0, 3'b101);
    check(count, 0);
    $display("test absent done");
    cfg_write(8'h64, 32'hffff_ffff);
    cfg_write(8'h68, 32'hffff_ffff);
    for (int ch = 0; ch < 4; ch++) begin
      for (int s = 0; s < 16; s++) begin
        for (int e = 0; e < 3; e++) begin
          off = (e == 0) ? 11'h000 : (e == 1) ? 11'h123 : 11'h7ff;
          a = base + 40'(ch * 32'h8000) + 40'(s * 32'h800) + 40'(off);
          host(a, e[0], {ch[15:0], s[15:0]}, 3'b110);
          check({cch, cslot, cfn, cofs}, {ch[1:0], s[3:0], off});
          check(cmod, s < 8);
          check({cwrite, cwdata}, {e[0], ch[15:0], s[15:0]});
        end
      end
    end
    $display("test map done");
    host(base - 40'h1, 1'b0, 32'h0, 3'b000);
    host(base + 40'h20000, 1'b0, 32'h0, 3'b000);
    host(base ^ 40'h80_0000_0000, 1'b0, 32'h0, 3'b000);
    $display("test miss done");
    cfg_write(8'h48, 32'h1235_ffff);
    cfg_write(8'h4c, 32'h0000_0012);
    cfg_read(8'h48, 32'h1234_0000);
    cfg_read(8'h4c, 32'h0000_0012);
    host(40'h12_1236_0000, 1'b0, 32'h0, 3'b000);
    host(base, 1'b0, 32'h0, 3'b000);
    base = 40'h12_1234_0000;
    host(base + 40'h1f8ff, 1'b0, 32'h0, 3'b110);
    check({cch, cslot, cfn, cofs}, {2'h3, 4'hf, 3'h0, 8'hff});
    $display("test relocate done");
    @(negedge i_clk);
    clr = 1'b1;
    @(negedge i_clk);
    clr = 1'b0;
    cfg_write(8'h64, 32'h0);
    cfg_write(8'h68, 32'h0000_0020);
    host(base + 40'h12800, 1'b0, 32'h0, 3'b110);
    host(base + 40'h13000, 1'b0, 32'h0, 3'b101);
    host(base + 40'h02800, 1'b1, 32'h0, 3'b101);
    check(seen, 64'h1 << 37);
    check(count, 1);
    $display("test presence done");
    // Reset in mid-run must bring back the default window and an empty mask
    @(negedge i_clk);
    i_reset = 1'b1;
    @(negedge i_clk);
    i_reset = 1'b0;
    cfg_read(8'h48, 32'hfe00_0000);
    cfg_read(8'h4c, 32'h0);
    cfg_read(8'h68, 32'h0);
    host(base + 40'h12800, 1'b0, 32'h0, 3'b000);
    host(40'h00_fe01_2800, 1'b0, 32'h0, 3'b101);
    check(count, 0);
    $display("test reset done");
    test_done();
  end
endmodule // tb_bwd_window_decoder
